/* hw/tfr_pkg.sv */
package tfr_pkg;

    // ----------------------------------------
    // Register word offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h00;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
    localparam logic [7:0] ADDR_ALT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_ALT_LOW = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CONTROL_ONE = 8'h14;
    localparam logic [7:0] ADDR_CONTROL_TWO = 8'h18;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int STATUS_OVF_BIT = 5;
    localparam int CONTROL_ONE_OVERFLOW_IRQ_ENABLE_BIT = 5;
    localparam int CONTROL_TWO_EDGE_BIT = 0;
    localparam int CONTROL_TWO_CC_LSB = 2;

    // ----------------------------------------
    // Values
    // ----------------------------------------
    localparam logic [15:0] COUNT_RESET = 16'hfffc;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [1:0] CC_DIV4 = 2'h0;
    localparam logic [1:0] CC_DIV2 = 2'h1;
    localparam logic [1:0] CC_DIV8 = 2'h2;
    localparam logic [1:0] CC_EXT = 2'h3;
    localparam logic [2:0] PRESC_DIV2_MASK = 3'h1;
    localparam logic [2:0] PRESC_DIV4_MASK = 3'h3;
    localparam logic [2:0] PRESC_DIV8_MASK = 3'h7;

    typedef struct packed {
        logic [7:0] adr;
        logic [7:0] dat;
        logic we;
        logic [3:0] sel;
        logic cyc;
        logic stb;
    } tfr_wb_req_t;

    typedef struct packed {
        logic [31:0] dat;
        logic ack;
    } tfr_wb_rsp_t;

    typedef struct packed {
        logic [15:0] count;
        logic [2:0] presc;
        logic [7:0] low_buffer;
        logic buffer_held;
        logic ovf;
        logic ovf_armed;
        logic overflow_irq_enable;
        logic [1:0] cc;
        logic edge_sel;
        logic [2:0] ext_sync;
        logic ext_prev;
        logic fall_tick;
        tfr_wb_rsp_t rsp;
        logic irq;
    } tfr_state_t;

endpackage : tfr_pkg

/* hw/tfr_timer.sv */
`timescale 1ns/1ps
// Behaviour
// - A 16-bit up-counter runs freely behind a programmable prescaler.
// - Counter clock is CPU clock over 2, 4 or 8, or the external pin.
// - Writing either low counter byte reloads the counter with FFFCh.
// - FFFCh is the only value ever loaded, in every mode.
// - Two read-only register pairs give the same count; alternate low spares the flag.
// - Reading the high byte first latches the low byte for a coherent read.
// - The latched low byte holds until the low byte is read.
// - After a completed sequence a lone low read returns the live low byte.
// - Rolling over from FFFFh to 0000h sets the overflow flag.
// - Interrupt asserts while enable set and CPU mask clear; otherwise stays pending.
// - Flag clears after a status read with flag set, then a low byte access.
// - Accesses to the alternate low byte never clear the overflow flag.
// - Counting goes on unchanged in wait mode.
// - Halt freezes the counter; interrupt wake resumes, reset wake restarts.
// - With the external clock, the edge-select bit picks the active edge.
// - Counter updates are aligned to the CPU clock edge.
// - An unbonded timer input reads as constant one.
// - Two such timers share nothing and start in step after reset.
module tfr_timer #(
    parameter bit EXT_PIN_BONDED = 1'b1
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire tfr_pkg::tfr_wb_req_t wb_req,
    output tfr_pkg::tfr_wb_rsp_t wb_rsp,
    input wire logic ext_clock_pin,
    input wire logic halt_mode,
    input wire logic wait_mode,
    input wire logic cpu_irq_mask,
    output logic timer_irq
);
    import tfr_pkg::*;

    initial
    begin
        if (EXT_PIN_BONDED !== 1'b0 && EXT_PIN_BONDED !== 1'b1)
        begin
            $error("EXT_PIN_BONDED must be 0 or 1");
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic addr_hit(input tfr_wb_req_t r, input logic [7:0] a);
        addr_hit = (r.adr[7:2] == a[7:2]);
    endfunction : addr_hit

    function automatic logic [2:0] presc_mask(input logic [1:0] cc);
        unique case (cc)
            CC_DIV2: presc_mask = PRESC_DIV2_MASK;
            CC_DIV4: presc_mask = PRESC_DIV4_MASK;
            default: presc_mask = PRESC_DIV8_MASK;
        endcase
    endfunction : presc_mask

    tfr_state_t state;
    tfr_state_t next_state;

    logic ext_in;
    logic access;
    logic rd;
    logic wr;
    logic tick;
    logic ext_now;
    logic ext_edge;
    logic wrap;
    logic status_rd;
    logic low_access;
    logic alt_low_access;
    logic high_rd;
    logic reload;
    logic [7:0] rdata;

    assign ext_in = EXT_PIN_BONDED ? ext_clock_pin : 1'b1;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        access = wb_req.cyc && wb_req.stb && !state.rsp.ack && wb_req.sel[0];
        rd = access && !wb_req.we;
        wr = access && wb_req.we;
        status_rd = rd && addr_hit(wb_req, ADDR_STATUS);
        low_access = access && addr_hit(wb_req, ADDR_COUNT_LOW);
        alt_low_access = access && addr_hit(wb_req, ADDR_ALT_LOW);
        high_rd = rd && (addr_hit(wb_req, ADDR_COUNT_HIGH) || addr_hit(wb_req, ADDR_ALT_HIGH));
        reload = wr && (addr_hit(wb_req, ADDR_COUNT_LOW) || addr_hit(wb_req, ADDR_ALT_LOW));

        // Pin synchroniser; stage 0 feeds stage 1 only
        next_state.ext_sync = {state.ext_sync[1:0], ext_in};
        ext_now = state.ext_sync[1];
        if (state.ext_sync[2] == state.ext_sync[1])
        begin
            next_state.ext_prev = ext_now;
        end
        ext_edge = (state.ext_sync[2] == state.ext_sync[1]) && (ext_now != state.ext_prev)
            && (ext_now == state.edge_sel);

        // Half-rate phase mirrors the CPU falling edge slot
        next_state.fall_tick = !state.fall_tick;
        tick = 1'b0;
        if (!halt_mode)
        begin
            if (state.cc == CC_EXT)
            begin
                tick = ext_edge;
            end
            else
            begin
                next_state.presc = state.presc + 3'h1;
                tick = ((state.presc & presc_mask(state.cc)) == presc_mask(state.cc));
            end
        end
        wrap = tick && (state.count == COUNT_MAX) && !reload;

        if (reload)
        begin
            next_state.count = COUNT_RESET;
            next_state.presc = 3'h0;
        end
        else if (tick)
        begin
            next_state.count = state.count + 16'h0001;
        end

        // Coherent 16-bit read
        rdata = 8'h00;
        if (high_rd && !state.buffer_held)
        begin
            next_state.low_buffer = state.count[7:0];
            next_state.buffer_held = 1'b1;
        end
        if (rd && (addr_hit(wb_req, ADDR_COUNT_LOW) || addr_hit(wb_req, ADDR_ALT_LOW)))
        begin
            next_state.buffer_held = 1'b0;
        end
        if (addr_hit(wb_req, ADDR_COUNT_HIGH) || addr_hit(wb_req, ADDR_ALT_HIGH))
        begin
            rdata = state.count[15:8];
        end
        else if (addr_hit(wb_req, ADDR_COUNT_LOW) || addr_hit(wb_req, ADDR_ALT_LOW))
        begin
            rdata = state.buffer_held ? state.low_buffer : state.count[7:0];
        end
        else if (addr_hit(wb_req, ADDR_STATUS))
        begin
            rdata[STATUS_OVF_BIT] = state.ovf;
        end
        else if (addr_hit(wb_req, ADDR_CONTROL_ONE))
        begin
            rdata[CONTROL_ONE_OVERFLOW_IRQ_ENABLE_BIT] = state.overflow_irq_enable;
        end
        else if (addr_hit(wb_req, ADDR_CONTROL_TWO))
        begin
            rdata[CONTROL_TWO_CC_LSB +: 2] = state.cc;
            rdata[CONTROL_TWO_EDGE_BIT] = state.edge_sel;
        end

        // Overflow flag and its two-step clear
        if (status_rd && state.ovf)
        begin
            next_state.ovf_armed = 1'b1;
        end
        if (low_access && state.ovf_armed && !alt_low_access)
        begin
            next_state.ovf = 1'b0;
            next_state.ovf_armed = 1'b0;
        end
        if (wrap)
        begin
            next_state.ovf = 1'b1;
        end

        if (wr && addr_hit(wb_req, ADDR_CONTROL_ONE))
        begin
            next_state.overflow_irq_enable = wb_req.dat[CONTROL_ONE_OVERFLOW_IRQ_ENABLE_BIT];
        end
        if (wr && addr_hit(wb_req, ADDR_CONTROL_TWO))
        begin
            next_state.cc = wb_req.dat[CONTROL_TWO_CC_LSB +: 2];
            next_state.edge_sel = wb_req.dat[CONTROL_TWO_EDGE_BIT];
        end

        next_state.rsp.ack = wb_req.cyc && wb_req.stb && !state.rsp.ack;
        next_state.rsp.dat = {24'h000000, rdata};
        next_state.irq = next_state.ovf && state.overflow_irq_enable && !cpu_irq_mask;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= '0;
            state.count <= COUNT_RESET;
            state.ext_sync <= 3'h7;
            state.ext_prev <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign wb_rsp = state.rsp;
    assign timer_irq = state.irq;

endmodule : tfr_timer

/* dv/tfr_cpu_model.sv */
`timescale 1ns/1ps
module tfr_cpu_model (
    input wire logic core_clk,
    output tfr_pkg::tfr_wb_req_t wb_req,
    input wire tfr_pkg::tfr_wb_rsp_t wb_rsp
);
    import tfr_pkg::*;
    initial wb_req = '0;
    // One classic cycle; ok stays low if no ack comes within the bound
    task automatic xfer(input logic [7:0] adr, input logic we, input logic [7:0] dat,
                        output logic [7:0] rd, output bit ok);
        ok = 1'b0;
        rd = 8'h00;
        @(posedge core_clk);
        wb_req <= '{adr: adr, dat: dat, we: we, sel: 4'h1, cyc: 1'b1, stb: 1'b1};
        for (int n = 0; n < 20 && !ok; n++)
        begin
            @(posedge core_clk);
            if (wb_rsp.ack === 1'b1)
            begin
                ok = 1'b1;
                rd = wb_rsp.dat[7:0];
            end
        end
        // Release at the edge that sampled ack high
        wb_req <= '0;
    endtask : xfer
endmodule : tfr_cpu_model

/* dv/tfr_timer_assertions.sv */
`timescale 1ns/1ps
module tfr_chk (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire tfr_pkg::tfr_wb_req_t wb_req,
    input wire tfr_pkg::tfr_wb_rsp_t wb_rsp,
    input wire logic ext_clock_pin,
    input wire logic halt_mode,
    input wire logic wait_mode,
    input wire logic cpu_irq_mask,
    input wire logic timer_irq
);
    import tfr_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    ack_pulse_a:
        assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack held");
    ack_answer_a:
        assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack) else $error("no ack");
    ack_cause_a:
        assert property ($rose(wb_rsp.ack) |-> $past(wb_req.cyc && wb_req.stb)) else $error("stray ack");
    dat_upper_a:
        assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0) else $error("upper data set");
    hole_read_a:
        assert property (wb_rsp.ack && $past(wb_req.adr) == 8'h1c && !$past(wb_req.we) |-> wb_rsp.dat == 32'h0)
            else $error("hole read nonzero");
    irq_mask_a:
        assert property (cpu_irq_mask [*3] |-> !timer_irq) else $error("irq while masked");
    irq_pend_a:
        assert property ((timer_irq && !cpu_irq_mask && !wb_req.cyc) [*3] |=> timer_irq) else $error("irq lost");
    reset_quiet_a:
        assert property ($rose(arst_n) |-> !wb_rsp.ack && !timer_irq) else $error("busy after reset");
endmodule : tfr_chk
bind tfr_timer tfr_chk chk_u (.core_clk(core_clk), .arst_n(arst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .ext_clock_pin(ext_clock_pin), .halt_mode(halt_mode), .wait_mode(wait_mode),
    .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq));

/* dv/tfr_timer_bench.sv */
`timescale 1ns/1ps
module tfr_timer_bench;
    import tfr_pkg::*;
    typedef struct packed {logic [7:0] adr; logic we; logic [7:0] dat; logic [7:0] exp;} tfr_row_t;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ext_clock_pin = 1'b0;
    logic halt_mode = 1'b1;
    logic wait_mode = 1'b0;
    logic cpu_irq_mask = 1'b1;
    tfr_wb_req_t wb_req;
    tfr_wb_rsp_t wb_rsp;
    logic timer_irq;
    logic [7:0] rd;
    logic [7:0] lo;
    logic [15:0] e;
    bit ok;
    int n_mismatch = 0;
    int checks_done = 0;
    // Counter frozen at its reset count while halted
    tfr_row_t rows [8] = '{'{8'h04, 1'b1, 8'h5a, 8'h00}, '{8'h00, 1'b0, 8'h00, 8'hff},
        '{8'h04, 1'b0, 8'h00, 8'hfc}, '{8'h08, 1'b0, 8'h00, 8'hff}, '{8'h0c, 1'b0, 8'h00, 8'hfc},
        '{8'h04, 1'b0, 8'h00, 8'hfc}, '{8'h10, 1'b0, 8'h00, 8'h00}, '{8'h1c, 1'b0, 8'h00, 8'h00}};
    always #5 core_clk = ~core_clk;
    tfr_timer dut_u (.core_clk(core_clk), .arst_n(arst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .ext_clock_pin(ext_clock_pin), .halt_mode(halt_mode), .wait_mode(wait_mode),
        .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq));
    tfr_cpu_model cpu_u (.core_clk(core_clk), .wb_req(wb_req), .wb_rsp(wb_rsp));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic bus(input logic [7:0] adr, input logic we, input logic [7:0] dat = 8'h00);
        cpu_u.xfer(adr, we, dat, rd, ok);
        if (!ok)
        begin
            n_mismatch++;
            summarize();
        end
    endtask : bus
    initial
    begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        foreach (rows[r])
        begin
            bus(rows[r].adr, rows[r].we, rows[r].dat);
            if (!rows[r].we)
                check(rd, rows[r].exp);
        end
        bus(ADDR_COUNT_HIGH, 1'b0);
        wait_mode <= 1'b1;
        halt_mode <= 1'b0;
        repeat (24) @(posedge core_clk);
        halt_mode <= 1'b1;
        bus(ADDR_ALT_HIGH, 1'b0);
        bus(ADDR_COUNT_LOW, 1'b0);
        check(rd, 8'hfc);
        bus(ADDR_ALT_LOW, 1'b0);
        lo = rd;
        bus(ADDR_COUNT_LOW, 1'b0);
        check(rd, lo);
        check(8'(lo inside {8'h01, 8'h02}), 8'h01);
        bus(ADDR_CONTROL_ONE, 1'b1, 8'h20);
        bus(ADDR_CONTROL_ONE, 1'b0);
        check(rd, 8'h20);
        repeat (3) @(posedge core_clk);
        check(8'(timer_irq), 8'h00);
        cpu_irq_mask <= 1'b0;
        repeat (4) @(posedge core_clk);
        check(8'(timer_irq), 8'h01);
        bus(ADDR_COUNT_LOW, 1'b0);
        bus(ADDR_STATUS, 1'b0);
        check(rd, 8'h20);
        bus(ADDR_ALT_LOW, 1'b1);
        bus(ADDR_STATUS, 1'b0);
        check(rd, 8'h20);
        bus(ADDR_COUNT_LOW, 1'b0);
        bus(ADDR_STATUS, 1'b0);
        check(rd, 8'h00);
        check(8'(timer_irq), 8'h00);
        halt_mode <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            bus(ADDR_CONTROL_TWO, 1'b1, {4'h0, CC_EXT, 1'b0, k[0]});
            bus(ADDR_ALT_LOW, 1'b1);
            // Active edges eight cycles apart
            repeat (3 + 2 * k)
            begin
                ext_clock_pin <= 1'b1;
                repeat (4) @(posedge core_clk);
                ext_clock_pin <= 1'b0;
                repeat (4) @(posedge core_clk);
            end
            e = 16'hfffc + 16'(3 + 2 * k);
            bus(ADDR_COUNT_HIGH, 1'b0);
            check(rd, e[15:8]);
            bus(ADDR_COUNT_LOW, 1'b0);
            check(rd, e[7:0]);
        end
        bus(ADDR_CONTROL_TWO, 1'b0);
        check(rd, 8'h0d);
        arst_n <= 1'b0;
        halt_mode <= 1'b1;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        bus(ADDR_COUNT_HIGH, 1'b0);
        check(rd, 8'hff);
        bus(ADDR_COUNT_LOW, 1'b0);
        check(rd, 8'hfc);
        summarize();
    end
endmodule : tfr_timer_bench
